// [core/hfp_pkg.sv]
package hfp_pkg;

  // Host bus geometry: word addresses, one 16-bit word each.
  localparam int ADDR_W = 6;
  localparam int DATA_W = 16;
  localparam int FIFO_DEPTH = 8;

  // Each data port takes a block of 16 aliased word addresses.
  localparam int ALIAS_BITS = 4;
  localparam logic [1:0] PORT_RXDATA = 2'h0;
  localparam logic [1:0] PORT_TXDATA = 2'h1;

  // Single-word ports and registers.
  localparam logic [5:0] ADDR_RXSTS_POP = 6'h20;
  localparam logic [5:0] ADDR_RXSTS_PEEK = 6'h21;
  localparam logic [5:0] ADDR_TXSTS_POP = 6'h22;
  localparam logic [5:0] ADDR_TXSTS_PEEK = 6'h23;
  localparam logic [5:0] ADDR_LEVEL = 6'h24;
  localparam logic [5:0] ADDR_EVENT = 6'h25;
  localparam logic [5:0] ADDR_CONTROL = 6'h26;

  // Event register bit positions and their access kinds.
  localparam int EV_RX_STALL = 0;
  localparam int EV_TX_STARVE = 1;
  localparam int EV_FAULT_HIGH = 2;
  localparam int EV_LINK_LOW = 3;
  localparam int EV_TX_DROP = 4;
  localparam int EV_W = 5;
  localparam logic [4:0] EVENT_RESET = 5'h00;

  // Control register bit positions.
  localparam int CTL_SOFT_RESET = 0;
  localparam int CTL_MAC_ENABLE = 1;
  localparam int CTL_KEEP = 2;
  localparam logic MAC_ENABLE_RESET = 1'b0;
  localparam logic KEEP_RESET = 1'b0;

  // Width of each count field in the level register.
  localparam int LEVEL_FIELD_W = 4;

endpackage : hfp_pkg

// [core/hfp_port_access.sv]
// How it works
// - Writes to read-only locations change nothing.
// - Write-only locations read back as zero.
// - Writing one clears bit; zero leaves it.
// - Clear-on-read bits return value, then clear.
// - Latched bits hold until their register is read.
// - Soft-reset-immune bits survive a software reset.
// - System reset loads every register's default value.
// - Four queues: RX status, RX data, TX status, TX data.
// - Data and RX status capacities are settable.
// - Both receive queues are read-only to host.
// - RX status pop port returns and removes head.
// - RX status peek port returns head, keeps it.
// - Each RX data read returns and removes head.
// - Sixteen word aliases reach the RX data port.
// - TX status pop port returns and removes head.
// - TX status peek port returns head, keeps it.
// - TX data port accepts writes only.
// - Sixteen word aliases reach the TX data port.

// Queue with registered flags and a registered head word; capacity limit is live.
module hfp_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8,
  localparam int CW = $clog2(DEPTH + 1),
  localparam int PW = $clog2(DEPTH)
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic inValid,
  input wire logic [WIDTH-1:0] inData,
  output logic inReady,
  output logic outValid,
  output logic [WIDTH-1:0] outData,
  input wire logic outReady,
  input wire logic [CW-1:0] limit,
  output logic [CW-1:0] count
);

  // Pointer wrap relies on a power-of-two depth.
  if (DEPTH < 2 || (1 << PW) != DEPTH) begin : gDepthCheck
    $error("hfp_fifo DEPTH must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wrPtr;
  logic [PW-1:0] rdPtr;
  logic doPush;
  logic doPop;
  logic [PW-1:0] next_rdPtr;
  logic [CW-1:0] next_count;
  logic [CW-1:0] capacity;

  // A limit of zero or above the depth means the full depth.
  assign capacity = (limit == '0 || limit > CW'(DEPTH)) ? CW'(DEPTH) : limit;
  assign doPush = inValid & inReady;
  assign doPop = outReady & outValid;
  assign next_rdPtr = rdPtr + PW'(doPop);
  assign next_count = count + CW'(doPush) - CW'(doPop);

  // Storage carries no reset; only the pointers define what is valid.
  always_ff @(posedge clk) begin
    if (ce && doPush) begin
      mem[wrPtr] <= inData;
    end
  end

  // The head is prefetched so the output stays a flop, bypassing a write into the head slot.
  always_ff @(posedge clk) begin
    if (reset) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
      inReady <= 1'b1;
      outValid <= 1'b0;
      outData <= '0;
    end else if (ce) begin
      wrPtr <= wrPtr + PW'(doPush);
      rdPtr <= next_rdPtr;
      count <= next_count;
      inReady <= next_count < capacity;
      outValid <= next_count != '0;
      outData <= (doPush && wrPtr == next_rdPtr) ? inData : mem[next_rdPtr];
    end
  end

  // A full queue never takes a word, whatever the limit did meanwhile.
  noOverfill_a: assert property (@(posedge clk) disable iff (reset)
    (count == CW'(DEPTH)) |-> !doPush) else $error("push into a full queue");

endmodule : hfp_fifo

// Host-side access to the four packet queues and the attribute-style status register.
module hfp_port_access #(
  parameter int DEPTH = hfp_pkg::FIFO_DEPTH,
  localparam int CW = $clog2(DEPTH + 1)
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic hostCsN,
  input wire logic hostRdN,
  input wire logic hostWrN,
  input wire logic [hfp_pkg::ADDR_W-1:0] hostAddr,
  input wire logic [hfp_pkg::DATA_W-1:0] hostDataIn,
  output logic [hfp_pkg::DATA_W-1:0] hostDataOut,
  output logic hostDataOe,
  input wire logic rxStsValid,
  input wire logic [hfp_pkg::DATA_W-1:0] rxStsData,
  output logic rxStsReady,
  input wire logic rxDataValid,
  input wire logic [hfp_pkg::DATA_W-1:0] rxDataWord,
  output logic rxDataReady,
  input wire logic txStsValid,
  input wire logic [hfp_pkg::DATA_W-1:0] txStsData,
  output logic txStsReady,
  output logic txDataValid,
  output logic [hfp_pkg::DATA_W-1:0] txDataWord,
  input wire logic txDataReady,
  input wire logic [CW-1:0] rxStsLimit,
  input wire logic [CW-1:0] rxDataLimit,
  input wire logic [CW-1:0] txDataLimit,
  input wire logic linkFault,
  input wire logic linkUp,
  output logic macEnable,
  output logic keepFlag
);

  localparam int SW = 3 + hfp_pkg::ADDR_W + hfp_pkg::DATA_W + 2;

  // Each count must fit its field in the level register.
  if (CW > hfp_pkg::LEVEL_FIELD_W) begin : gLevelCheck
    $error("hfp_port_access DEPTH too large for the level fields");
  end

  logic [SW-1:0] syncA;
  logic [SW-1:0] syncB;
  logic csS;
  logic rdS;
  logic wrS;
  logic faultS;
  logic linkS;
  logic [hfp_pkg::ADDR_W-1:0] addrS;
  logic [hfp_pkg::DATA_W-1:0] dataS;
  logic rdAct;
  logic wrAct;
  logic rdPrev;
  logic wrPrev;
  logic rdStart;
  logic wrStart;
  logic softResetPulse;
  logic rstAll;

  // Every host pin crosses two flops; the bus is assumed stable across the strobe.
  always_ff @(posedge clk) begin
    if (reset) begin
      syncA <= '0;
      syncB <= '0;
    end else if (ce) begin
      syncA <= {~hostCsN, ~hostRdN, ~hostWrN, hostAddr, hostDataIn, linkFault, linkUp};
      syncB <= syncA;
    end
  end

  assign {csS, rdS, wrS, addrS, dataS, faultS, linkS} = syncB;
  assign rdAct = csS & rdS;
  assign wrAct = csS & wrS;
  // Only the leading edge of a strobe acts, however long it is held.
  assign rdStart = rdAct & ~rdPrev;
  assign wrStart = wrAct & ~wrPrev;
  // Software reset returns queues and registers, except immune bits, to defaults; synchronisers and strobe edge flops see system reset only.
  assign rstAll = reset | softResetPulse;

  always_ff @(posedge clk) begin
    if (reset) begin
      rdPrev <= 1'b0;
      wrPrev <= 1'b0;
    end else if (ce) begin
      rdPrev <= rdAct;
      wrPrev <= wrAct;
    end
  end

  // Address decode; the data ports ignore the low address bits.
  logic isRxData, isTxData, isRxPop, isRxPeek, isTxPop, isTxPeek, isLevel, isEvent, isControl;
  assign isRxData = addrS[hfp_pkg::ADDR_W-1:hfp_pkg::ALIAS_BITS] == hfp_pkg::PORT_RXDATA;
  assign isTxData = addrS[hfp_pkg::ADDR_W-1:hfp_pkg::ALIAS_BITS] == hfp_pkg::PORT_TXDATA;
  assign isRxPop = addrS == hfp_pkg::ADDR_RXSTS_POP;
  assign isRxPeek = addrS == hfp_pkg::ADDR_RXSTS_PEEK;
  assign isTxPop = addrS == hfp_pkg::ADDR_TXSTS_POP;
  assign isTxPeek = addrS == hfp_pkg::ADDR_TXSTS_PEEK;
  assign isLevel = addrS == hfp_pkg::ADDR_LEVEL;
  assign isEvent = addrS == hfp_pkg::ADDR_EVENT;
  assign isControl = addrS == hfp_pkg::ADDR_CONTROL;

  // The four queues and their pop and push strobes.
  logic rxStsHeadValid;
  logic rxDataHeadValid;
  logic txStsHeadValid;
  logic txDataInReady;
  logic [hfp_pkg::DATA_W-1:0] rxStsHead;
  logic [hfp_pkg::DATA_W-1:0] rxDataHead;
  logic [hfp_pkg::DATA_W-1:0] txStsHead;
  logic [CW-1:0] rxStsCount;
  logic [CW-1:0] rxDataCount;
  logic [CW-1:0] txStsCount;
  logic [CW-1:0] txDataCount;
  logic rxStsPop, rxDataPop, txStsPop, txDataPush;
  assign rxStsPop = rdStart & isRxPop & rxStsHeadValid;
  assign rxDataPop = rdStart & isRxData & rxDataHeadValid;
  assign txStsPop = rdStart & isTxPop & txStsHeadValid;
  // Only writes feed the transmit data queue; receive queues take no writes.
  assign txDataPush = wrStart & isTxData;

  hfp_fifo #(.WIDTH(hfp_pkg::DATA_W), .DEPTH(DEPTH)) rxStsQueue (
    .clk(clk), .reset(rstAll), .ce(ce),
    .inValid(rxStsValid), .inData(rxStsData), .inReady(rxStsReady),
    .outValid(rxStsHeadValid), .outData(rxStsHead), .outReady(rxStsPop),
    .limit(rxStsLimit), .count(rxStsCount)
  );

  hfp_fifo #(.WIDTH(hfp_pkg::DATA_W), .DEPTH(DEPTH)) rxDataQueue (
    .clk(clk), .reset(rstAll), .ce(ce),
    .inValid(rxDataValid), .inData(rxDataWord), .inReady(rxDataReady),
    .outValid(rxDataHeadValid), .outData(rxDataHead), .outReady(rxDataPop),
    .limit(rxDataLimit), .count(rxDataCount)
  );

  hfp_fifo #(.WIDTH(hfp_pkg::DATA_W), .DEPTH(DEPTH)) txStsQueue (
    .clk(clk), .reset(rstAll), .ce(ce),
    .inValid(txStsValid), .inData(txStsData), .inReady(txStsReady),
    .outValid(txStsHeadValid), .outData(txStsHead), .outReady(txStsPop),
    .limit(CW'(DEPTH)), .count(txStsCount)
  );

  hfp_fifo #(.WIDTH(hfp_pkg::DATA_W), .DEPTH(DEPTH)) txDataQueue (
    .clk(clk), .reset(rstAll), .ce(ce),
    .inValid(txDataPush), .inData(dataS), .inReady(txDataInReady),
    .outValid(txDataValid), .outData(txDataWord), .outReady(txDataReady),
    .limit(txDataLimit), .count(txDataCount)
  );

  // Event register: sticky sources with set winning over any clear in the same cycle.
  logic [hfp_pkg::EV_W-1:0] eventReg;
  logic [hfp_pkg::EV_W-1:0] next_event;
  logic evRead, evWrite, rxStallEv, txStarveEv, txDropEv;
  assign evRead = rdStart & isEvent;
  assign evWrite = wrStart & isEvent;
  assign rxStallEv = rxDataValid & ~rxDataReady;
  assign txStarveEv = txDataReady & ~txDataValid;
  assign txDropEv = txDataPush & ~txDataInReady;
  assign next_event[hfp_pkg::EV_RX_STALL] = (eventReg[hfp_pkg::EV_RX_STALL]
    & ~(evWrite & dataS[hfp_pkg::EV_RX_STALL])) | rxStallEv;
  assign next_event[hfp_pkg::EV_TX_DROP] = (eventReg[hfp_pkg::EV_TX_DROP]
    & ~(evWrite & dataS[hfp_pkg::EV_TX_DROP])) | txDropEv;
  assign next_event[hfp_pkg::EV_TX_STARVE] = (eventReg[hfp_pkg::EV_TX_STARVE] & ~evRead) | txStarveEv;
  assign next_event[hfp_pkg::EV_FAULT_HIGH] = (eventReg[hfp_pkg::EV_FAULT_HIGH] & ~evRead) | faultS;
  assign next_event[hfp_pkg::EV_LINK_LOW] = evRead ? linkS : (eventReg[hfp_pkg::EV_LINK_LOW] & linkS);

  // Other event register bits are writable only as listed; everything else is read-only.
  always_ff @(posedge clk) begin
    if (rstAll) begin
      eventReg <= hfp_pkg::EVENT_RESET;
    end else if (ce) begin
      eventReg <= next_event;
    end
  end

  // Control: a self-clearing soft reset, an enable, and one bit that only system reset restores.
  always_ff @(posedge clk) begin
    if (rstAll) begin
      softResetPulse <= 1'b0;
      macEnable <= hfp_pkg::MAC_ENABLE_RESET;
    end else if (ce) begin
      softResetPulse <= wrStart & isControl & dataS[hfp_pkg::CTL_SOFT_RESET];
      if (wrStart && isControl) begin
        macEnable <= dataS[hfp_pkg::CTL_MAC_ENABLE];
      end
    end
  end

  // The immune bit sees the system reset alone.
  always_ff @(posedge clk) begin
    if (reset) begin
      keepFlag <= hfp_pkg::KEEP_RESET;
    end else if (ce && wrStart && isControl) begin
      keepFlag <= dataS[hfp_pkg::CTL_KEEP];
    end
  end

  // Read selection; the transmit data port and unmapped words read as zero.
  logic [hfp_pkg::DATA_W-1:0] levelWord;
  logic [hfp_pkg::DATA_W-1:0] controlWord;
  logic [hfp_pkg::DATA_W-1:0] readValue;
  assign levelWord = {hfp_pkg::LEVEL_FIELD_W'(rxStsCount), hfp_pkg::LEVEL_FIELD_W'(rxDataCount),
    hfp_pkg::LEVEL_FIELD_W'(txStsCount), hfp_pkg::LEVEL_FIELD_W'(txDataCount)};
  assign controlWord = hfp_pkg::DATA_W'({keepFlag, macEnable, 1'b0});
  assign readValue =
    (isRxData && rxDataHeadValid) ? rxDataHead :
    ((isRxPop || isRxPeek) && rxStsHeadValid) ? rxStsHead :
    ((isTxPop || isTxPeek) && txStsHeadValid) ? txStsHead :
    isLevel ? levelWord :
    isEvent ? hfp_pkg::DATA_W'(eventReg) :
    isControl ? controlWord :
    '0;

  // Read data is captured once at the strobe's leading edge and held while it lasts.
  always_ff @(posedge clk) begin
    if (rstAll) begin
      hostDataOut <= '0;
      hostDataOe <= 1'b0;
    end else if (ce) begin
      hostDataOe <= rdAct;
      if (rdStart) begin
        hostDataOut <= readValue;
      end
    end
  end

  roNoPop_a: assert property (@(posedge clk) disable iff (rstAll)
    (ce && wrStart && isRxPop) |=> rxStsCount >= $past(rxStsCount))
    else $error("write to read-only port removed an entry");

  woReadZero_a: assert property (@(posedge clk) disable iff (rstAll)
    (ce && rdStart && isTxData) |=> hostDataOut == '0)
    else $error("write-only port read back non-zero");

  w1cClears_a: assert property (@(posedge clk) disable iff (rstAll)
    (ce && evWrite && dataS[hfp_pkg::EV_RX_STALL] && !rxStallEv) |=> !eventReg[hfp_pkg::EV_RX_STALL])
    else $error("write-one did not clear the bit");

  rcReturnsClears_a: assert property (@(posedge clk) disable iff (rstAll)
    (ce && evRead && !txStarveEv) |=> !eventReg[hfp_pkg::EV_TX_STARVE]
    && hostDataOut[hfp_pkg::EV_TX_STARVE] == $past(eventReg[hfp_pkg::EV_TX_STARVE]))
    else $error("clear-on-read bit misbehaved");

  latchHolds_a: assert property (@(posedge clk) disable iff (rstAll)
    (eventReg[hfp_pkg::EV_FAULT_HIGH] && !(ce && evRead)) |=> eventReg[hfp_pkg::EV_FAULT_HIGH])
    else $error("latched bit dropped before a read");

  immuneKeep_a: assert property (@(posedge clk) disable iff (reset)
    softResetPulse |=> keepFlag == $past(keepFlag))
    else $error("immune bit changed on software reset");

  softDefaults_a: assert property (@(posedge clk) disable iff (reset)
    softResetPulse |=> macEnable == hfp_pkg::MAC_ENABLE_RESET && eventReg == hfp_pkg::EVENT_RESET
    && rxDataCount == '0 && !hostDataOe)
    else $error("software reset left a non-default value");

  peekKeeps_a: assert property (@(posedge clk) disable iff (rstAll)
    (ce && rdStart && isRxPeek) |=> rxStsCount >= $past(rxStsCount))
    else $error("peek removed an entry");

  popOne_a: assert property (@(posedge clk) disable iff (rstAll)
    (ce && rxStsPop) |=> rxStsCount + 1'b1 == $past(rxStsCount) + $past(rxStsValid & rxStsReady))
    else $error("status pop did not remove exactly one entry");

  aliasHead_a: assert property (@(posedge clk) disable iff (rstAll)
    (ce && rxDataPop) |=> hostDataOut == $past(rxDataHead) && !rxDataPop)
    else $error("data alias read wrong word or popped twice");

endmodule : hfp_port_access

// [sim/hfp_mac_model.sv]
// Stand-in for the MAC: pushes queued words into three streams and drains the TX data head.
module hfp_mac_model (
  input wire logic clk,
  input wire logic reset,
  output logic rxStsValid,
  output logic [15:0] rxStsData,
  input wire logic rxStsReady,
  output logic rxDataValid,
  output logic [15:0] rxDataWord,
  input wire logic rxDataReady,
  output logic txStsValid,
  output logic [15:0] txStsData,
  input wire logic txStsReady,
  input wire logic txDataValid,
  input wire logic [15:0] txDataWord,
  output logic txDataReady
);
  timeunit 1ns;
  timeprecision 1ps;
  // Words waiting per stream: 0 RX status, 1 RX data, 2 TX status.
  logic [15:0] pend [3][$];
  logic [15:0] got [$];
  logic txStall = 1'b1;
  logic [2:0] vld = 3'h0;
  logic [15:0] dat [3] = '{default: 16'h0000};
  wire [2:0] rdy = {txStsReady, rxDataReady, rxStsReady};

  // Stream outputs come from the per-stream registers.
  assign rxStsValid = vld[0];
  assign rxStsData = dat[0];
  assign rxDataValid = vld[1];
  assign rxDataWord = dat[1];
  assign txStsValid = vld[2];
  assign txStsData = dat[2];

  initial txDataReady = 1'b0;

  // A word stays put until ready is seen with it; idle lines invert their data every cycle so a stale word never passes.
  always @(posedge clk) begin
    if (reset) begin
      vld <= 3'h0;
      txDataReady <= 1'b0;
    end else begin
      for (int s = 0; s < 3; s++) begin
        if (vld[s] && rdy[s]) void'(pend[s].pop_front());
        if (pend[s].size() > 0) begin
          vld[s] <= 1'b1;
          dat[s] <= pend[s][0];
        end else begin
          vld[s] <= 1'b0;
          dat[s] <= ~dat[s];
        end
      end
      if (txDataValid && txDataReady) got.push_back(txDataWord);
      txDataReady <= !txStall;
    end
  end
endmodule : hfp_mac_model

// [sim/hfp_port_access_tb.sv]
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin errCount++; $display("wrong value at %0t: got %h want %h", $time, g, e); end end

module hfp_port_access_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [5:0] LV = hfp_pkg::ADDR_LEVEL;
  localparam logic [5:0] EV = hfp_pkg::ADDR_EVENT;
  localparam logic [5:0] CT = hfp_pkg::ADDR_CONTROL;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic csN = 1'b1, rdN = 1'b1, wrN = 1'b1, linkFault = 1'b0, linkUp = 1'b1;
  logic [5:0] addr = 6'h00;
  logic [15:0] din = 16'h0000;
  logic [3:0] rxStsLimit = 4'h0, rxDataLimit = 4'h0, txDataLimit = 4'h0;
  wire [15:0] dout, rsD, rdW, tsD, tdW;
  wire oe, rsV, rsR, rdV, rdR, tsV, tsR, tdV, tdR, macEnable, keepFlag;
  int errCount = 0;
  int compares = 0;
  int cycles = 0;

  hfp_port_access i_hfp_port_access (.clk(clk), .reset(reset), .ce(1'b1), .hostCsN(csN), .hostRdN(rdN),
    .hostWrN(wrN), .hostAddr(addr), .hostDataIn(din), .hostDataOut(dout), .hostDataOe(oe),
    .rxStsValid(rsV), .rxStsData(rsD), .rxStsReady(rsR), .rxDataValid(rdV), .rxDataWord(rdW),
    .rxDataReady(rdR), .txStsValid(tsV), .txStsData(tsD), .txStsReady(tsR), .txDataValid(tdV),
    .txDataWord(tdW), .txDataReady(tdR), .rxStsLimit(rxStsLimit), .rxDataLimit(rxDataLimit),
    .txDataLimit(txDataLimit), .linkFault(linkFault), .linkUp(linkUp), .macEnable(macEnable),
    .keepFlag(keepFlag));

  hfp_mac_model i_mac (.clk(clk), .reset(reset), .rxStsValid(rsV), .rxStsData(rsD), .rxStsReady(rsR),
    .rxDataValid(rdV), .rxDataWord(rdW), .rxDataReady(rdR), .txStsValid(tsV), .txStsData(tsD),
    .txStsReady(tsR), .txDataValid(tdV), .txDataWord(tdW), .txDataReady(tdR));

  // Free-running 125 MHz clock.
  initial begin
    forever #4 clk = ~clk;
  end

  // Hang guard: the 56 host accesses fit well inside this ceiling.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      errCount++;
      report_and_stop();
    end
  end

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask : idle

  // Pins are synchronised inside, so each strobe is held well past the two-flop delay and gaps stay wide.
  task automatic hread(input logic [5:0] a, output logic [15:0] d);
    @(posedge clk);
    csN <= 1'b0;
    rdN <= 1'b0;
    addr <= a;
    idle(5);
    d = dout;
    `CHK(oe, 1'b1)
    csN <= 1'b1;
    rdN <= 1'b1;
    idle(4);
    `CHK(oe, 1'b0)
  endtask : hread

  // Only mapped addresses are ever written; released data shows the inverse of the last word.
  task automatic hwrite(input logic [5:0] a, input logic [15:0] d);
    @(posedge clk);
    csN <= 1'b0;
    wrN <= 1'b0;
    addr <= a;
    din <= d;
    idle(4);
    csN <= 1'b1;
    wrN <= 1'b1;
    din <= ~d;
    idle(4);
  endtask : hwrite

  task automatic rd_chk(input logic [5:0] a, input logic [15:0] e);
    logic [15:0] d;
    hread(a, d);
    `CHK(d, e)
  endtask : rd_chk

  task automatic t_reset();
    `CHK({dout, oe, tdV, macEnable, keepFlag}, 20'h00000)
    `CHK({rsR, rdR, tsR}, 3'b111)
    rd_chk(LV, 16'h0000);
    $display("reset test done");
  endtask : t_reset

  // Latched link bits, clear-on-read starve bit.
  task automatic t_events();
    rd_chk(EV, 16'h0000);
    rd_chk(EV, 16'h0008);
    linkUp <= 1'b0;
    idle(3);
    linkUp <= 1'b1;
    idle(4);
    rd_chk(EV, 16'h0000);
    rd_chk(EV, 16'h0008);
    linkFault <= 1'b1;
    idle(3);
    linkFault <= 1'b0;
    idle(4);
    rd_chk(EV, 16'h000c);
    rd_chk(EV, 16'h0008);
    i_mac.txStall <= 1'b0;
    idle(3);
    i_mac.txStall <= 1'b1;
    idle(4);
    rd_chk(EV, 16'h000a);
    rd_chk(EV, 16'h0008);
    $display("event test done");
  endtask : t_events

  // Three words popped through three different aliases, each access popping once.
  task automatic t_rx_data();
    i_mac.pend[1].push_back(16'h1a2b);
    i_mac.pend[1].push_back(16'h3c4d);
    i_mac.pend[1].push_back(16'h5e6f);
    idle(8);
    hwrite(6'h03, 16'hffff);
    rd_chk(LV, 16'h0300);
    rd_chk(6'h00, 16'h1a2b);
    rd_chk(6'h0f, 16'h3c4d);
    rd_chk(6'h05, 16'h5e6f);
    rd_chk(6'h00, 16'h0000);
    rd_chk(LV, 16'h0000);
    // A one-word capacity stalls the MAC, which raises the write-one-to-clear stall bit.
    rxDataLimit <= 4'h1;
    i_mac.pend[1].push_back(16'h2468);
    i_mac.pend[1].push_back(16'h1357);
    idle(8);
    rd_chk(LV, 16'h0100);
    rd_chk(6'h09, 16'h2468);
    rd_chk(EV, 16'h0009);
    hwrite(EV, 16'h0001);
    rd_chk(EV, 16'h0008);
    rd_chk(6'h0a, 16'h1357);
    rxDataLimit <= 4'h0;
    $display("rx data test done");
  endtask : t_rx_data

  // Peek keeps the head, pop removes it, for both status queues.
  task automatic t_status();
    logic [5:0] pop;
    logic [15:0] base;
    for (int k = 0; k < 2; k++) begin
      i_mac.pend[2 * k].push_back(16'h0a01 + 16'(k) * 16'h0100);
      i_mac.pend[2 * k].push_back(16'h0a02 + 16'(k) * 16'h0100);
    end
    idle(8);
    hwrite(hfp_pkg::ADDR_RXSTS_POP, 16'h0000);
    hwrite(LV, 16'hffff);
    rd_chk(LV, 16'h2020);
    for (int k = 0; k < 2; k++) begin
      pop = k ? hfp_pkg::ADDR_TXSTS_POP : hfp_pkg::ADDR_RXSTS_POP;
      base = 16'h0a00 + 16'(k) * 16'h0100;
      rd_chk(pop + 6'h01, base + 16'h0001);
      rd_chk(pop + 6'h01, base + 16'h0001);
      rd_chk(pop, base + 16'h0001);
      rd_chk(pop + 6'h01, base + 16'h0002);
      rd_chk(pop, base + 16'h0002);
    end
    rd_chk(LV, 16'h0000);
    // A reduced status capacity holds the second word back until the first is popped.
    rxStsLimit <= 4'h1;
    i_mac.pend[0].push_back(16'h0c01);
    i_mac.pend[0].push_back(16'h0c02);
    idle(8);
    rd_chk(LV, 16'h1000);
    rd_chk(hfp_pkg::ADDR_RXSTS_POP, 16'h0c01);
    rd_chk(hfp_pkg::ADDR_RXSTS_POP, 16'h0c02);
    rxStsLimit <= 4'h0;
    $display("status test done");
  endtask : t_status

  // Fill the TX queue past a reduced capacity while the MAC stalls, then drain it.
  task automatic t_tx_data();
    txDataLimit <= 4'h3;
    hwrite(6'h10, 16'hc001);
    hwrite(6'h1f, 16'hc002);
    hwrite(6'h17, 16'hc003);
    hwrite(6'h1a, 16'hc004);
    rd_chk(6'h10, 16'h0000);
    rd_chk(LV, 16'h0003);
    rd_chk(EV, 16'h0018);
    hwrite(EV, 16'h0000);
    rd_chk(EV, 16'h0018);
    hwrite(EV, 16'h0010);
    rd_chk(EV, 16'h0008);
    i_mac.txStall <= 1'b0;
    idle(10);
    i_mac.txStall <= 1'b1;
    idle(4);
    `CHK(i_mac.got.size(), 3)
    for (int k = 0; k < 3; k++) `CHK(i_mac.got[k], 16'hc001 + 16'(k))
    rd_chk(LV, 16'h0000);
    txDataLimit <= 4'h0;
    $display("tx data test done");
  endtask : t_tx_data

  // Soft reset spares only the immune bit; a system reset clears it too.
  task automatic t_control();
    hwrite(CT, 16'h0006);
    `CHK({macEnable, keepFlag}, 2'b11)
    i_mac.pend[1].push_back(16'h7777);
    hwrite(CT, 16'h0007);
    `CHK({macEnable, keepFlag}, 2'b01)
    rd_chk(CT, 16'h0004);
    rd_chk(LV, 16'h0000);
    rd_chk(6'h30, 16'h0000);
    reset <= 1'b1;
    idle(2);
    reset <= 1'b0;
    idle(2);
    `CHK(keepFlag, 1'b0)
    $display("control test done");
  endtask : t_control

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", compares, errCount);
    if (errCount == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop

  // Main sequence.
  initial begin
    idle(12);
    reset <= 1'b0;
    idle(4);
    t_reset();
    t_events();
    t_rx_data();
    t_status();
    t_tx_data();
    t_control();
    report_and_stop();
  end
endmodule : hfp_port_access_tb
